// File: src/cmcr_top.sv
// Functional notes
// - Clock-input control bits 7..3 are writable spare bits resetting to 00100.
// - Clock-input bit 2, reset 0, selects low-voltage PECL for device clock input.
// - Clock-input bit 1, reset 0, selects low-voltage PECL for reference input.
// - Clock-input bit 0, reset 0, inverts the reference before alignment use.
// - A read-only 24-bit word reports reference edge position against device clock.
// - That position word spans indices 0x02c to 0x02e.
// - Input A full-scale code, 16-bit read-write at 0x030..0x031, resets 0xa000.
// - Input B full-scale code, identical, at 0x032..0x033, resets 0xa000.
// - Codes 0x2000, 0xa000, 0xffff mean 500, 800, 1000 mVpp.
// - Bypass bit 0 at 0x038, reset 0, uses 1.1 V supply as reference.
// - Timestamp control bit 0 at 0x03b, reset 0, enables the receiver.
// - Timestamp control bit 1, reset 0, selects low-voltage PECL; bits 7..2 spare.
// - Pre-emphasis register at 0x048 resets 0x00; bits 3..0 hold setting.
// - The pre-emphasis setting drives all sixteen serial lanes together.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
module cmcr_top #(
   parameter int NUM_LANES = 16
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire cmcr_pkg::cmcr_apb_req_s apb_req,
   output cmcr_pkg::cmcr_apb_rsp_s apb_rsp,
   input wire logic [23:0] edge_position_in,
   input wire logic ref_input_raw,
   output logic ref_for_alignment,
   output logic devclock_low_voltage_pecl_select,
   output logic ref_input_low_voltage_pecl_select,
   output logic ref_input_polarity_invert,
   output logic [15:0] input_a_fullscale_code,
   output logic [15:0] input_b_fullscale_code,
   output logic input_a_below_min,
   output logic input_b_below_min,
   output logic reference_bypass_bit,
   output logic stamp_input_receiver_enable,
   output logic stamp_input_low_voltage_pecl_select,
   output logic [3:0] lane_preemphasis_setting,
   output logic [NUM_LANES-1:0][3:0] lane_preemph
);
   import cmcr_pkg::*;

   // ------------------------------------------------------------------
   // Declarations.
   // ------------------------------------------------------------------
   cmcr_wr_s wr;
   logic rd_setup;
   logic [IDX_W-1:0] rd_idx;
   logic [7:0] rd_byte;
   logic [7:0] cfg_q [CFG_NUM];
   logic [7:0] clk_ctrl;
   logic [7:0] ref_byp;
   logic [7:0] stamp_ctrl;
   logic [7:0] preemph;

   logic [23:0] pos_ff;
   logic [23:0] nxt_pos;
   logic [15:0] pos_snap_ff;
   logic [15:0] nxt_pos_snap;
   logic ref_align_ff;
   logic nxt_ref_align;
   logic below_a_ff;
   logic nxt_below_a;
   logic below_b_ff;
   logic nxt_below_b;

   // ------------------------------------------------------------------
   // Bus slave.
   // ------------------------------------------------------------------
   cmcr_apb_slave u_apb (
      .ref_clk(ref_clk),
      .srst(srst),
      .apb_req(apb_req),
      .rd_byte(rd_byte),
      .apb_rsp(apb_rsp),
      .wr(wr),
      .rd_setup(rd_setup)
   );

   assign rd_idx = apb_req.paddr[ADDR_W-1:2];

   // ------------------------------------------------------------------
   // Configuration bytes, one instance per table slot.
   // ------------------------------------------------------------------
   // Reset values of every byte come from one table, so clock control starts at 0x20.
   generate
      for (genvar g = 0; g < CFG_NUM; g++) begin : g_cfg
         cmcr_cfg_byte #(
            .IDX(CFG_IDX[g]),
            .RST(CFG_RST[g])
         ) u_byte (
            .ref_clk(ref_clk),
            .srst(srst),
            .wr(wr),
            .q(cfg_q[g])
         );
      end
   endgenerate

   assign clk_ctrl = cfg_q[0];
   assign ref_byp = cfg_q[5];
   assign stamp_ctrl = cfg_q[6];
   assign preemph = cfg_q[7];

   // ------------------------------------------------------------------
   // Control outputs.
   // ------------------------------------------------------------------
   // Each control leaves the block straight from its storage flop.
   assign devclock_low_voltage_pecl_select = clk_ctrl[BIT_DEVICE_CLOCK_INPUT_PECL];
   assign ref_input_low_voltage_pecl_select = clk_ctrl[BIT_REF_PECL];
   assign ref_input_polarity_invert = clk_ctrl[BIT_REF_INV];
   // The analog front end maps the code piecewise to 500/800/1000 mVpp.
   assign input_a_fullscale_code = {cfg_q[1], cfg_q[2]};
   assign input_b_fullscale_code = {cfg_q[3], cfg_q[4]};
   assign reference_bypass_bit = ref_byp[BIT_BYPASS];
   assign stamp_input_receiver_enable = stamp_ctrl[BIT_STAMP_RECV];
   assign stamp_input_low_voltage_pecl_select = stamp_ctrl[BIT_STAMP_PECL];
   assign lane_preemphasis_setting = preemph[PE_MSB:0];

   // One global setting fans out to every lane; lanes cannot be tuned apart.
   generate
      for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
         assign lane_preemph[l] = preemph[PE_MSB:0];
      end
   endgenerate

   // ------------------------------------------------------------------
   // Status and reference path.
   // ------------------------------------------------------------------
   // The edge word is sampled every cycle. Reading its top byte freezes the two lower
   // bytes, so a three-byte read taken top first gives one coherent sample.
   always_comb begin
      nxt_pos = edge_position_in;
      nxt_pos_snap = pos_snap_ff;
      if (rd_setup && (rd_idx == IDX_POS_HI)) begin
         nxt_pos_snap = pos_ff[15:0];
      end
      nxt_ref_align = ref_input_raw ^ clk_ctrl[BIT_REF_INV];
      nxt_below_a = input_a_fullscale_code < FS_MIN_CODE;
      nxt_below_b = input_b_fullscale_code < FS_MIN_CODE;
   end

   // Register only.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pos_ff <= RST_POS;
         pos_snap_ff <= RST_POS[15:0];
         ref_align_ff <= 1'b0;
         below_a_ff <= 1'b0;
         below_b_ff <= 1'b0;
      end else begin
         pos_ff <= nxt_pos;
         pos_snap_ff <= nxt_pos_snap;
         ref_align_ff <= nxt_ref_align;
         below_a_ff <= nxt_below_a;
         below_b_ff <= nxt_below_b;
      end
   end

   assign ref_for_alignment = ref_align_ff;
   assign input_a_below_min = below_a_ff;
   assign input_b_below_min = below_b_ff;

   // ------------------------------------------------------------------
   // Read multiplexer.
   // ------------------------------------------------------------------
   // Unmapped indices return zero; the slave flags them with an error as well.
   always_comb begin
      rd_byte = 8'h00;
      case (rd_idx)
         IDX_POS_HI: rd_byte = pos_ff[23:16];
         IDX_POS_MID: rd_byte = pos_snap_ff[15:8];
         IDX_POS_LO: rd_byte = pos_snap_ff[7:0];
         default: begin
            for (int i = 0; i < CFG_NUM; i++) begin
               if (cmcr_is_mapped(rd_idx) && (CFG_IDX[i] == rd_idx)) begin
                  rd_byte = cfg_q[i];
               end
            end
         end
      endcase
   end

   // ------------------------------------------------------------------
   // Assertions.
   // ------------------------------------------------------------------
   default clocking cb_main @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   sequence s_wr_at(logic [IDX_W-1:0] i);
      wr.valid && (wr.idx == i);
   endsequence

   sequence s_rd_setup_at(logic [IDX_W-1:0] i);
      rd_setup && (rd_idx == i);
   endsequence

   sequence s_access_wr_status;
      apb_req.psel && apb_req.penable && apb_req.pwrite && cmcr_is_status(rd_idx);
   endsequence

   a_clk_reset_val: assert property (@(posedge ref_clk) disable iff (1'b0)
      srst |=> (clk_ctrl == 8'h20) && !devclock_low_voltage_pecl_select)
      else $error("Clock-input control did not reset to 0x20.");

   a_device_clock_input_pecl_wr: assert property (s_wr_at(IDX_CLK_CTRL) |=>
      devclock_low_voltage_pecl_select == $past(wr.data[2]))
      else $error("Device clock PECL select did not follow the write.");

   a_ref_pecl_wr: assert property (s_wr_at(IDX_CLK_CTRL) |=>
      ref_input_low_voltage_pecl_select == $past(wr.data[1]))
      else $error("Reference PECL select did not follow the write.");

   a_ref_invert_path: assert property (##1 ref_for_alignment ==
      ($past(ref_input_raw) ^ $past(ref_input_polarity_invert)))
      else $error("Aligned reference does not match the polarity setting.");

   a_pos_capture: assert property (##1 pos_ff == $past(edge_position_in))
      else $error("Edge position word lags its source by more than one cycle.");

   a_pos_top_byte: assert property (s_rd_setup_at(IDX_POS_HI) ##1 apb_req.penable |->
      apb_rsp.prdata == {24'h000000, $past(pos_ff[23:16])})
      else $error("Top byte of the edge word read back wrongly.");

   a_pos_low_snap: assert property (s_rd_setup_at(IDX_POS_HI) |=>
      pos_snap_ff == $past(pos_ff[15:0]))
      else $error("Lower edge bytes were not frozen on the top-byte read.");

   a_fs_reset_val: assert property (@(posedge ref_clk) disable iff (1'b0)
      srst |=> (input_a_fullscale_code == 16'ha000) && (input_b_fullscale_code == 16'ha000))
      else $error("Full-scale codes did not reset to 0xa000.");

   a_fsa_hi_wr: assert property (s_wr_at(IDX_FSA_HI) |=>
      input_a_fullscale_code[15:8] == $past(wr.data))
      else $error("Input A upper code byte did not take the write.");

   a_fsb_lo_wr: assert property (s_wr_at(IDX_FSB_LO) |=>
      input_b_fullscale_code[7:0] == $past(wr.data) && $stable(input_a_fullscale_code))
      else $error("Input B lower code byte write went wrong.");

   a_below_min_flag: assert property (##1 input_a_below_min ==
      ($past(input_a_fullscale_code) < 16'h2000))
      else $error("Input A low-code flag is wrong.");

   a_bypass_wr: assert property (s_wr_at(IDX_REF_BYP) |=>
      reference_bypass_bit == $past(wr.data[0]))
      else $error("Reference bypass did not follow the write.");

   a_stamp_ctrl_wr: assert property (s_wr_at(IDX_STAMP_CTRL) |=>
      stamp_input_receiver_enable == $past(wr.data[0])
      && stamp_input_low_voltage_pecl_select == $past(wr.data[1]))
      else $error("Timestamp controls did not follow the write.");

   a_preemph_wr: assert property (s_wr_at(IDX_PREEMPH) |=>
      lane_preemphasis_setting == $past(wr.data[3:0]))
      else $error("Pre-emphasis setting did not follow the write.");

   a_lane_fanout: assert property (lane_preemph[NUM_LANES-1] == lane_preemphasis_setting
      && lane_preemph[0] == lane_preemphasis_setting)
      else $error("Lanes disagree on pre-emphasis.");

   a_status_wr_ignored: assert property (s_access_wr_status |-> !wr.valid && !apb_rsp.pslverr
      ##1 $stable(pos_snap_ff) || $past(rd_setup))
      else $error("A write to the edge word had an effect.");

endmodule : cmcr_top

// File: src/cmcr_pkg.sv
package cmcr_pkg;

   // ------------------------------------------------------------------
   // Bus geometry.
   // ------------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int IDX_W = 10;

   // ------------------------------------------------------------------
   // Register indices; the byte address on the bus is four times these.
   // ------------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_CLK_CTRL = 10'h02a;
   localparam logic [IDX_W-1:0] IDX_POS_HI = 10'h02c;
   localparam logic [IDX_W-1:0] IDX_POS_MID = 10'h02d;
   localparam logic [IDX_W-1:0] IDX_POS_LO = 10'h02e;
   localparam logic [IDX_W-1:0] IDX_FSA_HI = 10'h030;
   localparam logic [IDX_W-1:0] IDX_FSA_LO = 10'h031;
   localparam logic [IDX_W-1:0] IDX_FSB_HI = 10'h032;
   localparam logic [IDX_W-1:0] IDX_FSB_LO = 10'h033;
   localparam logic [IDX_W-1:0] IDX_REF_BYP = 10'h038;
   localparam logic [IDX_W-1:0] IDX_STAMP_CTRL = 10'h03b;
   localparam logic [IDX_W-1:0] IDX_PREEMPH = 10'h048;

   // ------------------------------------------------------------------
   // Values after reset.
   // ------------------------------------------------------------------
   localparam logic [7:0] RST_CLK_CTRL = 8'h20;
   localparam logic [15:0] RST_FS = 16'ha000;
   localparam logic [7:0] RST_REF_BYP = 8'h00;
   localparam logic [7:0] RST_STAMP = 8'h00;
   localparam logic [7:0] RST_PREEMPH = 8'h00;
   localparam logic [23:0] RST_POS = 24'h000000;

   // ------------------------------------------------------------------
   // Field positions and code points.
   // ------------------------------------------------------------------
   localparam int BIT_DEVICE_CLOCK_INPUT_PECL = 2;
   localparam int BIT_REF_PECL = 1;
   localparam int BIT_REF_INV = 0;
   localparam int BIT_BYPASS = 0;
   localparam int BIT_STAMP_RECV = 0;
   localparam int BIT_STAMP_PECL = 1;
   localparam int PE_MSB = 3;
   localparam logic [15:0] FS_MIN_CODE = 16'h2000;

   // ------------------------------------------------------------------
   // Configuration byte table: slot order, index and reset value.
   // ------------------------------------------------------------------
   localparam int CFG_NUM = 8;
   localparam logic [IDX_W-1:0] CFG_IDX [CFG_NUM] = '{IDX_CLK_CTRL, IDX_FSA_HI, IDX_FSA_LO,
      IDX_FSB_HI, IDX_FSB_LO, IDX_REF_BYP, IDX_STAMP_CTRL, IDX_PREEMPH};
   localparam logic [7:0] CFG_RST [CFG_NUM] = '{RST_CLK_CTRL, RST_FS[15:8], RST_FS[7:0],
      RST_FS[15:8], RST_FS[7:0], RST_REF_BYP, RST_STAMP, RST_PREEMPH};

   // ------------------------------------------------------------------
   // Carriers.
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
      logic [3:0] pstrb;
   } cmcr_apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } cmcr_apb_rsp_s;

   typedef struct packed {
      logic valid;
      logic [IDX_W-1:0] idx;
      logic [7:0] data;
   } cmcr_wr_s;

   // ------------------------------------------------------------------
   // Decoding shared by the bus slave and the read multiplexer.
   // ------------------------------------------------------------------
   function automatic logic cmcr_is_status(input logic [IDX_W-1:0] idx);
      cmcr_is_status = (idx == IDX_POS_HI) || (idx == IDX_POS_MID) || (idx == IDX_POS_LO);
   endfunction : cmcr_is_status

   function automatic logic cmcr_is_mapped(input logic [IDX_W-1:0] idx);
      logic hit;
      hit = cmcr_is_status(idx);
      for (int i = 0; i < CFG_NUM; i++) begin
         if (CFG_IDX[i] == idx) begin
            hit = 1'b1;
         end
      end
      cmcr_is_mapped = hit;
   endfunction : cmcr_is_mapped

endpackage : cmcr_pkg

// File: src/cmcr_cfg_byte.sv
`timescale 1ns/1ns
module cmcr_cfg_byte #(
   parameter logic [9:0] IDX = 10'h000,
   parameter logic [7:0] RST = 8'h00
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire cmcr_pkg::cmcr_wr_s wr,
   output logic [7:0] q
);
   import cmcr_pkg::*;

   logic [7:0] byte_ff;
   logic [7:0] nxt_byte;

   // ------------------------------------------------------------------
   // Storage.
   // ------------------------------------------------------------------
   // Whole byte is stored, reserved bits included, so software reads back what it wrote.
   always_comb begin
      nxt_byte = byte_ff;
      if (wr.valid && (wr.idx == IDX)) begin
         nxt_byte = wr.data;
      end
   end

   // Register only.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         byte_ff <= RST;
      end else begin
         byte_ff <= nxt_byte;
      end
   end

   assign q = byte_ff;

endmodule : cmcr_cfg_byte

// File: src/cmcr_apb_slave.sv
`timescale 1ns/1ns
module cmcr_apb_slave (
   input wire logic ref_clk,
   input wire logic srst,
   input wire cmcr_pkg::cmcr_apb_req_s apb_req,
   input wire logic [7:0] rd_byte,
   output cmcr_pkg::cmcr_apb_rsp_s apb_rsp,
   output cmcr_pkg::cmcr_wr_s wr,
   output logic rd_setup
);
   import cmcr_pkg::*;

   logic [IDX_W-1:0] idx;
   logic setup;
   logic mapped;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic err_ff;
   logic nxt_err;

   assign idx = apb_req.paddr[ADDR_W-1:2];
   assign setup = apb_req.psel & ~apb_req.penable;
   assign mapped = cmcr_is_mapped(idx);

   // ------------------------------------------------------------------
   // Answer path.
   // ------------------------------------------------------------------
   // Read data and error are settled during the setup cycle, so the access phase never waits.
   always_comb begin
      nxt_prdata = prdata_ff;
      nxt_err = err_ff;
      if (setup) begin
         nxt_err = ~mapped;
         nxt_prdata = (apb_req.pwrite | ~mapped) ? 32'h00000000 : {24'h000000, rd_byte};
      end
   end

   // Register only.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         prdata_ff <= 32'h00000000;
         err_ff <= 1'b0;
      end else begin
         prdata_ff <= nxt_prdata;
         err_ff <= nxt_err;
      end
   end

   // Zero wait states; the error flag is shown only while the access phase lasts.
   assign apb_rsp.prdata = prdata_ff;
   assign apb_rsp.pready = 1'b1;
   assign apb_rsp.pslverr = err_ff & apb_req.psel & apb_req.penable;

   // Writes to the status bytes are dropped here without an error.
   assign wr.valid = apb_req.psel & apb_req.penable & apb_req.pwrite & apb_req.pstrb[0]
                     & mapped & ~cmcr_is_status(idx);
   assign wr.idx = idx;
   assign wr.data = apb_req.pwdata[7:0];
   assign rd_setup = setup & ~apb_req.pwrite;

endmodule : cmcr_apb_slave

// File: verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import cmcr_pkg::*;

   // ------------------------------------------------------------------
   // Stimulus and observation signals.
   // ------------------------------------------------------------------
   logic ref_clk;
   logic srst;
   cmcr_apb_req_s req;
   cmcr_apb_rsp_s rsp;
   logic [23:0] edge_in;
   logic raw;
   logic exp_align;
   logic align_on;
   logic align_q;
   logic dev_pecl, ref_pecl, ref_inv, fsa_low, fsb_low, byp, st_en, st_pecl;
   logic [15:0] fsa, fsb;
   logic [3:0] pe;
   logic [15:0][3:0] lanes;
   int fails, checked, seed;
   logic [7:0] shadow [CFG_NUM];
   logic [31:0] rd;
   logic err;
   logic [23:0] pos;
   // Values after reset, in the slot order of the configuration table.
   localparam logic [7:0] EXP_RST [CFG_NUM] = '{8'h20, 8'ha0, 8'h00, 8'ha0, 8'h00, 8'h00, 8'h00, 8'h00};

   cmcr_top #(.NUM_LANES(16)) u_dut (.ref_clk(ref_clk), .srst(srst), .apb_req(req), .apb_rsp(rsp),
      .edge_position_in(edge_in), .ref_input_raw(raw), .ref_for_alignment(align_q),
      .devclock_low_voltage_pecl_select(dev_pecl), .ref_input_low_voltage_pecl_select(ref_pecl),
      .ref_input_polarity_invert(ref_inv), .input_a_fullscale_code(fsa), .input_b_fullscale_code(fsb),
      .input_a_below_min(fsa_low), .input_b_below_min(fsb_low), .reference_bypass_bit(byp),
      .stamp_input_receiver_enable(st_en), .stamp_input_low_voltage_pecl_select(st_pecl),
      .lane_preemphasis_setting(pe), .lane_preemph(lanes));

   // ------------------------------------------------------------------
   // Clock, checking helpers and the closing task.
   // ------------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic finish_test();
      $display("checks made %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : finish_test

   // One APB transfer; the request is held until pready is seen high at an access edge.
   task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [7:0] wd,
                      input logic [3:0] strb, output logic [31:0] rdat, output logic erv);
      int n;
      n = 0;
      @(posedge ref_clk);
      req.paddr <= {idx, 2'b00};
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= wr;
      req.pwdata <= {24'h000000, wd};
      req.pstrb <= strb;
      @(posedge ref_clk);
      req.penable <= 1'b1;
      // The answer is taken at the rising edge that sees pready, before that edge's updates land.
      do begin
         @(posedge ref_clk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 50);
      if (n >= 50) chk("pready", 32'h1, {31'h0, rsp.pready});
      rdat = rsp.prdata;
      erv = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb

   // Compares every control output against the shadow copy of the bytes.
   task automatic check_ports();
      @(negedge ref_clk);
      chk("clock bits", {29'h0, shadow[0][2:0]}, {29'h0, dev_pecl, ref_pecl, ref_inv});
      chk("range a", {16'h0, shadow[1], shadow[2]}, {16'h0, fsa});
      chk("range b", {16'h0, shadow[3], shadow[4]}, {16'h0, fsb});
      chk("bypass", {31'h0, shadow[5][0]}, {31'h0, byp});
      chk("stamp", {30'h0, shadow[6][1:0]}, {30'h0, st_pecl, st_en});
      for (int l = 0; l < 16; l++) chk("lane", {28'h0, shadow[7][3:0]}, {28'h0, lanes[l]});
      chk("preemph", {28'h0, shadow[7][3:0]}, {28'h0, pe});
   endtask : check_ports

   task automatic write_slot(input int i, input logic [7:0] v);
      apb(1'b1, CFG_IDX[i], v, 4'h1, rd, err);
      shadow[i] = v;
   endtask : write_slot

   // Reference path: registered raw input XOR the invert bit, one cycle late.
   always @(posedge ref_clk) begin
      exp_align <= raw ^ ref_inv;
      raw <= 1'($random(seed));
      align_on <= !srst;
   end

   always @(negedge ref_clk) begin
      if (align_on) chk("alignment", {31'h0, exp_align}, {31'h0, align_q});
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      fails++;
      finish_test();
   end

   // ------------------------------------------------------------------
   // Main sequence.
   // ------------------------------------------------------------------
   initial begin
      seed = 49500;
      srst = 1'b1;
      req = '0;
      edge_in = 24'h000000;
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      for (int i = 0; i < CFG_NUM; i++) begin
         shadow[i] = EXP_RST[i];
         apb(1'b0, CFG_IDX[i], 8'h00, 4'h0, rd, err);
         chk("reset byte", {24'h0, EXP_RST[i]}, rd);
      end
      check_ports();
      $display("test reset values done");
      // Random bytes into every slot, all-ones first, then read back.
      for (int r = 0; r < 4; r++) begin
         for (int i = 0; i < CFG_NUM; i++) write_slot(i, (r == 0) ? 8'hff : 8'($random(seed)));
         for (int i = 0; i < CFG_NUM; i++) begin
            apb(1'b0, CFG_IDX[i], 8'h00, 4'h0, rd, err);
            chk("readback", {24'h0, shadow[i]}, rd);
         end
         check_ports();
      end
      // A write with its strobe low must leave the byte alone.
      apb(1'b1, IDX_PREEMPH, ~shadow[7], 4'h0, rd, err);
      check_ports();
      $display("test random writes done");
      // Codes on both sides of the recommended minimum.
      write_slot(1, 8'h1f);
      write_slot(2, 8'hff);
      write_slot(3, 8'h20);
      write_slot(4, 8'h00);
      check_ports();
      @(negedge ref_clk);
      chk("below min", 32'h2, {30'h0, fsa_low, fsb_low});
      $display("test range corners done");
      // Status word: top byte read freezes the lower two bytes.
      pos = 24'($random(seed));
      @(posedge ref_clk);
      edge_in <= pos;
      apb(1'b0, IDX_POS_HI, 8'h00, 4'h0, rd, err);
      chk("pos hi", {24'h0, pos[23:16]}, rd);
      edge_in <= ~pos;
      apb(1'b0, IDX_POS_MID, 8'h00, 4'h0, rd, err);
      chk("pos mid", {24'h0, pos[15:8]}, rd);
      apb(1'b0, IDX_POS_LO, 8'h00, 4'h0, rd, err);
      chk("pos lo", {24'h0, pos[7:0]}, rd);
      // Writes come before any new top-byte read, so the frozen bytes must still hold the old sample.
      apb(1'b1, IDX_POS_HI, 8'h5a, 4'h1, rd, err);
      chk("pos write err", 32'h0, {31'h0, err});
      apb(1'b1, IDX_POS_LO, 8'h5a, 4'h1, rd, err);
      apb(1'b0, IDX_POS_LO, 8'h00, 4'h0, rd, err);
      chk("pos lo after write", {24'h0, pos[7:0]}, rd);
      pos = ~pos;
      apb(1'b0, IDX_POS_HI, 8'h00, 4'h0, rd, err);
      chk("pos hi after write", {24'h0, pos[23:16]}, rd);
      $display("test status word done");
      // Unmapped places answer with an error and read zero.
      apb(1'b0, 10'h02b, 8'h00, 4'h0, rd, err);
      chk("unmapped read", 32'h1, {rd[30:0], err});
      apb(1'b1, 10'h034, 8'h77, 4'h1, rd, err);
      chk("unmapped write", 32'h1, {31'h0, err});
      check_ports();
      $display("test unmapped done");
      finish_test();
   end

endmodule : tb_top
